// >>> pio_pkg.sv
// package for the parallel port block: address map, bit positions,
// reset values, stop-mode codes and the pad bundle.
// assumes a 32-bit apb slave and three eight-pin ports (a, f, g).
package pio_pkg;

	localparam int PIO_PORTS = 3;
	localparam int PIO_PINS = 8;
	localparam int PIO_AW = 8;

	// port indices, also the port field of the address
	localparam logic [1:0] PIO_PA = 2'h0;
	localparam logic [1:0] PIO_PF = 2'h1;
	localparam logic [1:0] PIO_PG = 2'h2;

	// register index inside a port block (address bits 3:2)
	localparam logic [1:0] PIO_R_DATA = 2'h0;
	localparam logic [1:0] PIO_R_DIR = 2'h1;
	localparam logic [1:0] PIO_R_PULL = 2'h2;
	localparam logic [1:0] PIO_R_SLEW = 2'h3;

	// byte offsets: port block at 0x10 steps, register at 4-byte steps
	localparam logic [7:0] PIO_PORT_STEP = 8'h10;
	localparam logic [7:0] PIO_CTRL_OFF = 8'h30;

	// control register fields
	localparam int PIO_ACK_BIT = 0;
	localparam int PIO_HOLD_BIT = 1;

	// port g pins with alternate owners
	localparam int PIO_G_BDM = 0;
	localparam int PIO_G_OSC1 = 1;
	localparam int PIO_G_OSC2 = 2;

	localparam logic [7:0] PIO_REG_RST = 8'h00;
	localparam logic [31:0] PIO_RD_ZERO = 32'h0000_0000;

	typedef enum logic [3:0]
	{
		PIO_RUN = 4'h1,
		PIO_DEEP = 4'h2,
		PIO_MID = 4'h4,
		PIO_LIGHT = 4'h8
	} pio_stop_t;

	// per-pin drive state of all three ports
	typedef struct packed
	{
		logic [2:0][7:0] out;
		logic [2:0][7:0] oe_n;
		logic [2:0][7:0] pu;
		logic [2:0][7:0] slew;
	} pio_pads_t;

	// reset state: drivers off, pullups off
	localparam pio_pads_t PIO_PADS_RST = '{out: '0, oe_n: '1,
		pu: '0, slew: '0};

endpackage

// >>> pio_port_ctrl.sv
// parallel port control for ports a, f and g behind an apb slave.
// assumes pad_in is synchronous to pclk and that the stop-mode
// controller, keyboard unit, debug pin and oscillator sit outside.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// Overview of operation
// - reset leaves every pin an input with driver and pullup off.
// - direction one drives the pin; data reads return the latch.
// - direction zero releases the pin; data reads return the pin level.
// - pullup bit acts on inputs only; outputs keep pullup off.
// - slew bit acts on outputs only; inputs ignore it.
// - keyboard-owned port a pin is an input; slew bit ignored.
// - keyboard-owned port a input still follows its pullup bit.
// - port g pin zero is the debug pin in reset, later general i/o under its direction bit.
// - debug-owned g pin zero ignores direction, pullup and slew.
// - oscillator-owned g pins one and two ignore all port bits.
// - deepest stop clears registers; pins go to reset state.
// - intermediate stop entry latches every pin's drive state.
// - latched pins hold until software writes one to acknowledge outside intermediate stop, or until deepest stop.
// - lightest stop keeps registers and pins unchanged.
module pio_port_ctrl
	import pio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0][7:0] pad_in,
	output pio_pads_t pads,
	input wire logic [7:0] keyb_en,
	input wire logic bdm_owns_g0,
	input wire logic osc_owns_g1,
	input wire logic osc_owns_g2,
	input wire pio_stop_t stop_mode,
	output logic pads_held
);

	logic [2:0][7:0] data_q;
	logic [2:0][7:0] dir_q;
	logic [2:0][7:0] pull_q;
	logic [2:0][7:0] slew_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic pready_q;
	logic pslverr_q;
	logic hold_q;
	pio_stop_t mode_q;
	pio_pads_t pads_q;
	pio_pads_t pads_d;
	logic [1:0] a_port;
	logic [1:0] a_reg;
	logic hit_port;
	logic hit_ctrl;
	logic acc_start;
	logic wr_en;
	logic ack_wr;
	logic mid_entry;
	logic pwr_down;

	// address decode: aligned words, ports at 0x00/0x10/0x20, ctrl 0x30
	assign a_port = paddr[5:4];
	assign a_reg = paddr[3:2];
	assign hit_port = (paddr[7:6] == 2'h0) && (a_port != 2'h3)
		&& (paddr[1:0] == 2'h0);
	assign hit_ctrl = (paddr == PIO_CTRL_OFF);

	// one wait state: pready rises in the second access cycle
	assign acc_start = psel && penable && !pready_q;
	assign wr_en = psel && penable && pready_q && pwrite;
	assign ack_wr = wr_en && hit_ctrl && pwdata[PIO_ACK_BIT];

	// register contents are lost while the core is powered down
	assign pwr_down = (stop_mode == PIO_DEEP) || (stop_mode == PIO_MID);
	assign mid_entry = (stop_mode == PIO_MID) && (mode_q != PIO_MID);

	// per-port registers and pad decode
	for (genvar p = 0; p < PIO_PORTS; p++)
	begin : g_port
		// software writes land only at the edge where pready is seen
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				data_q[p] <= PIO_REG_RST;
				dir_q[p] <= PIO_REG_RST;
				pull_q[p] <= PIO_REG_RST;
				slew_q[p] <= PIO_REG_RST;
			end
			else if (pwr_down)
			begin
				data_q[p] <= PIO_REG_RST;
				dir_q[p] <= PIO_REG_RST;
				pull_q[p] <= PIO_REG_RST;
				slew_q[p] <= PIO_REG_RST;
			end
			else if (wr_en && hit_port && a_port == 2'(p))
			begin
				// data latch is written whatever the direction
				if (a_reg == PIO_R_DATA)
					data_q[p] <= pwdata[7:0];
				if (a_reg == PIO_R_DIR)
					dir_q[p] <= pwdata[7:0];
				if (a_reg == PIO_R_PULL)
					pull_q[p] <= pwdata[7:0];
				if (a_reg == PIO_R_SLEW)
					slew_q[p] <= pwdata[7:0];
			end
		end

		for (genvar b = 0; b < PIO_PINS; b++)
		begin : g_pin
			logic own;
			logic keyb;
			logic drv;
			// alternate owners take the pin away from the port bits
			assign own = (p == 2) && ((b == PIO_G_BDM && bdm_owns_g0)
				|| (b == PIO_G_OSC1 && osc_owns_g1)
				|| (b == PIO_G_OSC2 && osc_owns_g2));
			assign keyb = (p == 0) && keyb_en[b];
			assign drv = dir_q[p][b] && !keyb && !own;
			assign pads_d.oe_n[p][b] = !drv;
			assign pads_d.out[p][b] = drv && data_q[p][b];
			// pullup only on an input the port still owns
			assign pads_d.pu[p][b] = !drv && !own
				&& pull_q[p][b];
			assign pads_d.slew[p][b] = drv && slew_q[p][b];
		end
	end

	// pad drive flops: reset state in deep stop, frozen while held
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pads_q <= PIO_PADS_RST;
		else if (stop_mode == PIO_DEEP)
			pads_q <= PIO_PADS_RST;
		else if (!hold_q)
			pads_q <= pads_d;
	end

	// hold flag: set on intermediate-stop entry, cleared by ack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_q <= 1'b0;
		else if (mid_entry)
			hold_q <= 1'b1;
		else if (stop_mode == PIO_DEEP)
			hold_q <= 1'b0;
		else if (ack_wr && stop_mode != PIO_MID)
			hold_q <= 1'b0;
	end

	// previous stop mode, for entry detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= PIO_RUN;
		else
			mode_q <= stop_mode;
	end

	// read mux; data reads depend on direction per bit
	always_comb
	begin
		rd_d = PIO_RD_ZERO;
		if (hit_ctrl)
			rd_d[PIO_HOLD_BIT] = hold_q;
		else if (hit_port)
		begin
			unique case (a_reg)
				PIO_R_DATA: rd_d[7:0] = (dir_q[a_port] & data_q[a_port])
					| (~dir_q[a_port] & pad_in[a_port]);
				PIO_R_DIR: rd_d[7:0] = dir_q[a_port];
				PIO_R_PULL: rd_d[7:0] = pull_q[a_port];
				PIO_R_SLEW: rd_d[7:0] = slew_q[a_port];
			endcase
		end
	end

	// apb answer flops; unmapped addresses answer with pslverr
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= PIO_RD_ZERO;
		end
		else
		begin
			pready_q <= acc_start;
			pslverr_q <= acc_start && !hit_port && !hit_ctrl;
			if (acc_start && !pwrite)
				prdata_q <= rd_d;
			else if (acc_start)
				prdata_q <= PIO_RD_ZERO;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pads = pads_q;
	assign pads_held = hold_q;

	// checks, all in the pclk domain
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_deep_reset_pins: assert property (
		stop_mode == PIO_DEEP |=> pads_q.oe_n == '1 && pads_q.pu == '0)
	else $error("pins not in reset state during deep stop");

	a_held_pins_freeze: assert property (
		hold_q ##1 hold_q |-> $stable(pads_q))
	else $error("held pins changed");

	a_mid_entry_hold: assert property (
		mid_entry |=> hold_q [*2])
	else $error("hold not taken on intermediate stop entry");

	a_ack_release: assert property (
		hold_q && !mid_entry && stop_mode == PIO_RUN && !ack_wr
		|=> hold_q)
	else $error("hold released without acknowledge");

	a_ack_clears: assert property (
		ack_wr && stop_mode == PIO_RUN |=> !hold_q)
	else $error("acknowledge did not release hold");

	a_dir_drives_f: assert property (
		!hold_q && stop_mode == PIO_RUN
		|=> pads_q.oe_n[PIO_PF] == ~$past(dir_q[PIO_PF]))
	else $error("port f driver does not follow direction");

	a_read_data_mux: assert property (
		acc_start && !pwrite && hit_port && a_reg == PIO_R_DATA
		|=> prdata_q[7:0] == (($past(dir_q[a_port]) & $past(data_q[a_port]))
		| (~$past(dir_q[a_port]) & $past(pad_in[a_port]))))
	else $error("data read returned wrong source");

	a_pullup_outputs: assert property (
		(pads_q.pu & ~pads_q.oe_n) == '0)
	else $error("pullup on while driving");

	a_slew_inputs: assert property (
		(pads_q.slew & pads_q.oe_n) == '0)
	else $error("slew control on an input pin");

	a_keyb_input: assert property (
		!hold_q |=> ($past(keyb_en) & ~pads_q.oe_n[PIO_PA]) == '0)
	else $error("keyboard pin driven");

	a_bdm_release: assert property (
		bdm_owns_g0 && !hold_q |=> pads_q.oe_n[PIO_PG][PIO_G_BDM]
		&& !pads_q.pu[PIO_PG][PIO_G_BDM])
	else $error("debug pin not released");

	a_osc_release: assert property (
		osc_owns_g1 && !hold_q |=> pads_q.oe_n[PIO_PG][PIO_G_OSC1]
		&& !pads_q.out[PIO_PG][PIO_G_OSC1])
	else $error("oscillator pin not released");

	a_data_write: assert property (
		wr_en && hit_port && a_reg == PIO_R_DATA && !pwr_down
		|=> data_q[$past(a_port)] == $past(pwdata[7:0]))
	else $error("data latch not written");

	// reset leaves pins released and registers clear
	a_reset_pins: assert property (
		$rose(presetn) |-> pads_q == PIO_PADS_RST && dir_q == '0
		&& pull_q == '0)
	else $error("pins not in reset state after reset");

	// bus answer: one wait state, one-cycle pready
	a_ready_one_wait: assert property (
		acc_start |=> pready_q)
	else $error("pready not one cycle after access");

	a_ready_pulse: assert property (
		pready_q |=> !pready_q)
	else $error("pready longer than one cycle");

	a_unmapped_error: assert property (
		acc_start && !hit_port && !hit_ctrl |=> pslverr_q
		&& prdata_q == PIO_RD_ZERO)
	else $error("unmapped access not refused");

	a_hold_status: assert property (
		acc_start && !pwrite && hit_ctrl
		|=> prdata_q[PIO_HOLD_BIT] == $past(hold_q))
	else $error("hold status read wrong");

	a_ack_ignored_mid: assert property (
		hold_q && stop_mode == PIO_MID |=> hold_q)
	else $error("hold dropped during intermediate stop");

	// deepest stop wipes registers and the hold
	a_deep_clears: assert property (
		stop_mode == PIO_DEEP |=> data_q == '0 && dir_q == '0
		&& pull_q == '0 && slew_q == '0 && !hold_q)
	else $error("registers kept in deep stop");

	a_light_keeps: assert property (
		stop_mode == PIO_LIGHT && !wr_en
		|=> $stable(data_q) && $stable(dir_q) && $stable(pull_q))
	else $error("registers changed in lightest stop");

	// only bits with direction zero are judged; driven pins keep pullup off
	a_key_pullup: assert property (
		!hold_q && stop_mode == PIO_RUN
		|=> (~$past(dir_q[PIO_PA]) & ($past(pull_q[PIO_PA])
		^ pads_q.pu[PIO_PA])) == '0)
	else $error("port a pullup does not follow its bit");

	a_osc2_release: assert property (
		osc_owns_g2 && !hold_q |=> pads_q.oe_n[PIO_PG][PIO_G_OSC2]
		&& !pads_q.pu[PIO_PG][PIO_G_OSC2]
		&& !pads_q.slew[PIO_PG][PIO_G_OSC2])
	else $error("second oscillator pin not released");

	a_g0_general: assert property (
		!bdm_owns_g0 && !hold_q && stop_mode == PIO_RUN
		|=> pads_q.oe_n[PIO_PG][PIO_G_BDM]
		== !$past(dir_q[PIO_PG][PIO_G_BDM]))
	else $error("g pin zero does not follow direction");

	a_slew_f_outputs: assert property (
		!hold_q && stop_mode == PIO_RUN
		|=> pads_q.slew[PIO_PF] == ($past(dir_q[PIO_PF])
		& $past(slew_q[PIO_PF])))
	else $error("port f slew does not follow its bit");

	c_mid_entry: cover property (mid_entry);
	c_hold_read: cover property (acc_start && hit_ctrl && hold_q);
	c_ack_release: cover property (hold_q ##1 !hold_q);
	c_deep_stop: cover property (stop_mode == PIO_DEEP);
	c_bad_addr: cover property (pready_q && pslverr_q);

endmodule

// >>> pio_pad_model.sv
// external circuit on the port pins: a source per pin plus open lines.
// assumes the pad bundle of the port block and the bus clock.
`timescale 1ns/100ps
module pio_pad_model
	import pio_pkg::*;
(
	input wire logic pclk,
	input wire pio_pads_t pads,
	input wire logic [2:0][7:0] ext_en,
	input wire logic [2:0][7:0] ext_val,
	output logic [2:0][7:0] pin_lvl
);
	logic flt_q = 1'b0;
	// an open line wanders, so a toggle exposes reads of floating pins
	always @(posedge pclk)
		flt_q <= ~flt_q;
	// port driver wins, then the outside source, then pullup or float
	assign pin_lvl = ~pads.oe_n & pads.out | pads.oe_n & (ext_en & ext_val
		| ~ext_en & (pads.pu | {24{flt_q}}));
endmodule

// >>> pio_port_ctrl_tb.sv
// self-checking bench of the parallel port block with an apb master.
// assumes the pad model above on the pin side.
`timescale 1ns/100ps
module pio_port_ctrl_tb;
	import pio_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pslverr, pready, pads_held;
	logic bdm, osc1, osc2, errv;
	logic [7:0] paddr, keyb_en;
	logic [31:0] pwdata, prdata, rdv;
	logic [2:0][7:0] pad_in, ext_en, ext_val;
	pio_stop_t stop_mode;
	pio_pads_t pads;
	int n_mismatch = 0;
	int n_tests = 0;
	pio_port_ctrl pio_port_ctrl_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pads(pads),
		.keyb_en(keyb_en), .bdm_owns_g0(bdm), .osc_owns_g1(osc1),
		.osc_owns_g2(osc2), .stop_mode(stop_mode), .pads_held(pads_held));
	pio_pad_model pio_pad_model_i (.pclk(pclk), .pads(pads),
		.ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pad_in));
	// 200 MHz bus clock
	always #2.5 pclk = ~pclk;
	// wide enough for the whole pad bundle; callers size their values
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_reset;
		chk(pads, PIO_PADS_RST);
		apb(1'b0, 8'h14, 8'h00);
		chk(96'(rdv), 96'h0);
		bdm <= 1'b0;
		$display("test reset done");
	endtask
	task automatic t_portf;
		ext_en[1] <= 8'hFF;
		ext_val[1] <= 8'h3C;
		apb(1'b1, 8'h10, 8'hA5);
		apb(1'b0, 8'h10, 8'h00);
		chk(96'(rdv), 96'h3C);
		apb(1'b1, 8'h18, 8'hFF);
		apb(1'b1, 8'h1C, 8'h3C);
		tick(2);
		chk(96'({pads.pu[1], pads.oe_n[1], pads.slew[1]}),
			96'hFFFF00);
		apb(1'b1, 8'h14, 8'hF0);
		tick(2);
		chk(96'(pads.out[1] & 8'hF0), 96'hA0);
		chk(96'({pads.oe_n[1], pads.pu[1], pads.slew[1]}),
			96'h0F0F30);
		apb(1'b0, 8'h10, 8'h00);
		chk(96'(rdv), 96'hAC);
		apb(1'b0, 8'h40, 8'h00);
		chk(96'({errv, rdv}), 96'h100000000);
		$display("test port f done");
	endtask
	task automatic t_alt;
		keyb_en <= 8'hFF;
		osc1 <= 1'b1;
		osc2 <= 1'b1;
		bdm <= 1'b1;
		apb(1'b1, 8'h04, 8'hFF);
		apb(1'b1, 8'h08, 8'h0F);
		apb(1'b1, 8'h0C, 8'hFF);
		apb(1'b1, 8'h24, 8'hFF);
		apb(1'b1, 8'h2C, 8'hFF);
		tick(2);
		chk(96'({pads.oe_n[0], pads.slew[0], pads.pu[0]}),
			96'hFF000F);
		chk(96'({pads.oe_n[2], pads.slew[2]}), 96'h07F8);
		keyb_en <= 8'h00;
		osc1 <= 1'b0;
		osc2 <= 1'b0;
		bdm <= 1'b0;
		tick(3);
		chk(96'({pads.oe_n[0], pads.pu[0], pads.slew[0]}),
			96'hFF);
		chk(96'(pads.oe_n[2]), 96'h0);
		$display("test owners done");
	endtask
	task automatic t_stop;
		stop_mode <= PIO_LIGHT;
		tick(3);
		stop_mode <= PIO_RUN;
		apb(1'b0, 8'h14, 8'h00);
		chk(96'({rdv[7:0], pads.oe_n[1]}), 96'hF00F);
		stop_mode <= PIO_MID;
		tick(3);
		stop_mode <= PIO_RUN;
		tick(3);
		// registers are cleared now, so the pullups prove the latch
		chk(96'({pads_held, pads.oe_n[1], pads.pu[1]}),
			96'h10F0F);
		// software restores before it acknowledges
		apb(1'b1, 8'h14, 8'hF0);
		apb(1'b1, 8'h10, 8'hA5);
		apb(1'b1, 8'h18, 8'hFF);
		apb(1'b1, 8'h1C, 8'h3C);
		apb(1'b0, 8'h30, 8'h00);
		chk(96'(rdv), 96'h2);
		apb(1'b1, 8'h30, 8'h01);
		tick(3);
		chk(96'({pads_held, pads.oe_n[1], pads.out[1]}),
			96'h0FA0);
		chk(96'({pads.pu[1], pads.slew[1]}), 96'h0F30);
		stop_mode <= PIO_DEEP;
		tick(3);
		chk(pads, PIO_PADS_RST);
		stop_mode <= PIO_RUN;
		apb(1'b1, 8'h14, 8'hFF);
		tick(2);
		chk(96'(pads.oe_n[1]), 96'h0);
		$display("test stop modes done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, well above the roughly 120 cycles the tests need
	initial
	begin
		tick(3000);
		n_mismatch++;
		report_and_stop();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, osc1, osc2, bdm} = 7'h01;
		{paddr, pwdata, keyb_en, ext_en, ext_val} = '0;
		stop_mode = PIO_RUN;
		tick(5);
		presetn <= 1'b1;
		tick(1);
		t_reset();
		t_portf();
		t_alt();
		t_stop();
		report_and_stop();
	end
endmodule
